//--- sdh_pkg.sv
package sdh_pkg;
	// Register byte offsets
	localparam logic [7:0] SDH_OFF_ARG = 8'h00;
	localparam logic [7:0] SDH_OFF_CMD = 8'h04;
	localparam logic [7:0] SDH_OFF_RSPIDX = 8'h08;
	localparam logic [7:0] SDH_OFF_RSP1 = 8'h0C;
	localparam logic [7:0] SDH_OFF_RSP2 = 8'h10;
	localparam logic [7:0] SDH_OFF_RSP3 = 8'h14;
	localparam logic [7:0] SDH_OFF_RSP4 = 8'h18;
	localparam logic [7:0] SDH_OFF_CLK = 8'h1C;
	localparam logic [7:0] SDH_OFF_STAT = 8'h20;
	// Command word fields
	localparam int SDH_CMD_WIDTH = 12;
	localparam int SDH_CMD_SUSP_BIT = 11;
	localparam int SDH_CMD_EN_BIT = 10;
	localparam int SDH_CMD_PEND_BIT = 9;
	localparam int SDH_CMD_IRQ_BIT = 8;
	localparam int SDH_CMD_RSP_HI = 7;
	localparam int SDH_CMD_RSP_LO = 6;
	localparam int SDH_CMD_IDX_HI = 5;
	// Reply wait codes
	localparam logic [1:0] SDH_RSP_SHORT = 2'h1;
	localparam logic [1:0] SDH_RSP_LONG = 2'h3;
	// Clock control fields
	localparam int SDH_CLK_BYP_BIT = 8;
	localparam int SDH_DIV_WIDTH = 8;
	// Status bits
	localparam int SDH_ST_BUSY = 0;
	localparam int SDH_ST_RSP = 1;
	localparam int SDH_ST_TMO = 2;
	localparam int SDH_ST_SENT = 3;
	localparam int SDH_ST_IRQ = 4;
	localparam int SDH_ST_SUSP = 5;
	localparam int SDH_ST_WIDTH = 6;
	// Frame lengths in card clock bits
	localparam logic [7:0] SDH_CMD_BITS = 8'h30;
	localparam logic [7:0] SDH_SHORT_BITS = 8'h30;
	localparam logic [7:0] SDH_LONG_BITS = 8'h88;
	// Response timeout in card clocks
	localparam logic [6:0] SDH_RSP_TIMEOUT = 7'h40;
	// Reset values
	localparam logic [31:0] SDH_ARG_RST = 32'h0000_0000;
	localparam logic [31:0] SDH_RSP_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		SDH_IDLE,
		SDH_PEND,
		SDH_SEND,
		SDH_IRQW,
		SDH_RWAIT,
		SDH_RECV
	} sdh_cmd_state_t;
endpackage : sdh_pkg

//--- sdh_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdh_clk_if;
	logic [7:0] divisor;
	logic bypass;
	logic rise_tick;
	logic fall_tick;
	modport gen (input divisor, input bypass, output rise_tick, output fall_tick);
	modport use_side (output divisor, output bypass, input rise_tick, input fall_tick);
endinterface : sdh_clk_if
`default_nettype wire

//--- sdh_card_clk.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_card_clk
	import sdh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	sdh_clk_if.gen ck,
	output logic card_clock_pin
);
	typedef struct packed {
		logic [8:0] cnt;
		logic pin;
		logic rise;
		logic fall;
	} sdh_ck_state_t;

	sdh_ck_state_t s_reg;
	sdh_ck_state_t s_next;

	// Period of divisor plus two host clocks, or two host clocks in bypass
	always_comb begin
		logic [8:0] period;
		period = {1'b0, ck.divisor} + 9'h002;
		s_next = s_reg;
		if (ck.bypass) begin
			s_next.cnt = 9'h000;
			s_next.pin = ~s_reg.pin;
		end else begin
			s_next.cnt = (s_reg.cnt >= period - 9'h001) ? 9'h000 : s_reg.cnt + 9'h001;
			s_next.pin = (s_next.cnt >= (period >> 1));
		end
		s_next.rise = s_next.pin & ~s_reg.pin;
		s_next.fall = ~s_next.pin & s_reg.pin;
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign card_clock_pin = s_reg.pin;
	assign ck.rise_tick = s_reg.rise;
	assign ck.fall_tick = s_reg.fall;
endmodule : sdh_card_clk
`default_nettype wire

//--- sdh_cmd_path.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_cmd_path
	import sdh_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic card_clock_pin,
	output logic cmd_out,
	output logic cmd_oe,
	input wire logic cmd_in,
	input wire logic data_busy,
	input wire logic card_irq,
	output logic suspend_done
);
	typedef struct packed {
		sdh_cmd_state_t st;
		logic [31:0] arg;
		logic [SDH_CMD_WIDTH-1:0] cmd;
		logic [5:0] rsp_idx;
		logic [31:0] rsp1;
		logic [31:0] rsp2;
		logic [31:0] rsp3;
		logic [31:0] rsp4;
		logic [SDH_DIV_WIDTH-1:0] divisor;
		logic bypass;
		logic [SDH_ST_WIDTH-1:0] flags;
		logic [135:0] shreg;
		logic [7:0] bitcnt;
		logic [6:0] tmo;
		logic line_out;
		logic line_oe;
		logic susp;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
	} sdh_state_t;

	sdh_state_t s_reg;
	sdh_state_t s_next;
	sdh_clk_if ck ();

	// CRC7 over the first 40 frame bits, x^7 + x^3 + 1
	function automatic logic [6:0] sdh_crc7(input logic [39:0] bits);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = bits[i] ^ c[6];
			c = {c[5:0], 1'b0};
			c[0] = fb;
			c[3] = c[3] ^ fb;
		end
		return c;
	endfunction : sdh_crc7

	// Card clock generator
	sdh_card_clk u_clk (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.ck(ck.gen),
		.card_clock_pin(card_clock_pin)
	);

	assign ck.divisor = s_reg.divisor;
	assign ck.bypass = s_reg.bypass;

	always_comb begin
		logic accept;
		logic [47:0] frame;
		logic [39:0] head;
		logic [135:0] sh;
		logic [7:0] rlen;
		logic [SDH_CMD_WIDTH-1:0] wcmd;
		logic [SDH_ST_WIDTH-1:0] wclr;
		logic [SDH_ST_WIDTH-1:0] wset;
		accept = hsel & hready & htrans[1];
		// argument and index form the frame head
		head = {1'b0, 1'b1, s_reg.cmd[SDH_CMD_IDX_HI:0], s_reg.arg};
		frame = {head, sdh_crc7(head), 1'b1};
		sh = {s_reg.shreg[134:0], cmd_in};
		// reply length from the wait field
		rlen = (s_reg.cmd[SDH_CMD_RSP_HI:SDH_CMD_RSP_LO] == SDH_RSP_LONG) ? SDH_LONG_BITS : SDH_SHORT_BITS;
		wcmd = hwdata[SDH_CMD_WIDTH-1:0];
		wclr = '0;
		wset = '0;
		s_next = s_reg;
		s_next.ready = 1'b1;
		s_next.susp = 1'b0;

		// Bus address phase: latch writes, prefetch reads
		s_next.wr_pend = accept & hwrite;
		if (accept) begin
			s_next.wr_addr = haddr[7:0];
		end
		if (accept && !hwrite) begin
			unique case (haddr[7:0])
				SDH_OFF_ARG: s_next.rdata = s_reg.arg;
				SDH_OFF_CMD: s_next.rdata = {20'h00000, s_reg.cmd};
				SDH_OFF_RSPIDX: s_next.rdata = {26'h0000000, s_reg.rsp_idx};
				SDH_OFF_RSP1: s_next.rdata = s_reg.rsp1;
				SDH_OFF_RSP2: s_next.rdata = s_reg.rsp2;
				SDH_OFF_RSP3: s_next.rdata = s_reg.rsp3;
				SDH_OFF_RSP4: s_next.rdata = {s_reg.rsp4[31:1], 1'b0};
				SDH_OFF_CLK: s_next.rdata = {23'h000000, s_reg.bypass, s_reg.divisor};
				SDH_OFF_STAT: s_next.rdata = {26'h0000000, s_reg.flags[SDH_ST_WIDTH-1:1], s_reg.st != SDH_IDLE};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end

		// Command state machine
		unique case (s_reg.st)
			SDH_IDLE: begin
				s_next.line_oe = 1'b0;
			end
			SDH_PEND: begin
				// hold until data transfer ends, only when asked
				if (!data_busy || !s_reg.cmd[SDH_CMD_PEND_BIT]) begin
					s_next.st = SDH_SEND;
					s_next.shreg = {88'h0, frame};
					s_next.bitcnt = 8'h00;
				end
			end
			SDH_SEND: begin
				if (ck.fall_tick) begin
					if (s_reg.bitcnt == SDH_CMD_BITS) begin
						s_next.line_oe = 1'b0;
						s_next.line_out = 1'b1;
						wset[SDH_ST_SENT] = 1'b1;
						s_next.tmo = 7'h00;
						if (s_reg.cmd[SDH_CMD_IRQ_BIT]) begin
							s_next.st = SDH_IRQW;
						end else if (s_reg.cmd[SDH_CMD_RSP_LO]) begin
							s_next.st = SDH_RWAIT;
						end else begin
							s_next.st = SDH_IDLE;
						end
					end else begin
						s_next.line_oe = 1'b1;
						s_next.line_out = s_reg.shreg[47];
						s_next.shreg = {s_reg.shreg[134:0], 1'b0};
						s_next.bitcnt = s_reg.bitcnt + 8'h01;
					end
				end
			end
			SDH_IRQW: begin
				if (card_irq) begin
					wset[SDH_ST_IRQ] = 1'b1;
					s_next.st = s_reg.cmd[SDH_CMD_RSP_LO] ? SDH_RWAIT : SDH_IDLE;
				end
			end
			SDH_RWAIT: begin
				if (ck.rise_tick) begin
					if (!cmd_in) begin
						s_next.st = SDH_RECV;
						s_next.shreg = 136'h0;
						s_next.bitcnt = 8'h01;
					end else if (!s_reg.cmd[SDH_CMD_IRQ_BIT]) begin
						s_next.tmo = s_reg.tmo + 7'h01;
						if (s_reg.tmo == SDH_RSP_TIMEOUT - 7'h01) begin
							wset[SDH_ST_TMO] = 1'b1;
							s_next.st = SDH_IDLE;
						end
					end
				end
			end
			SDH_RECV: begin
				if (ck.rise_tick) begin
					s_next.shreg = sh;
					s_next.bitcnt = s_reg.bitcnt + 8'h01;
					if (s_reg.bitcnt + 8'h01 == rlen) begin
						s_next.st = SDH_IDLE;
						wset[SDH_ST_RSP] = 1'b1;
						if (rlen == SDH_LONG_BITS) begin
							// reserved all-ones field lands as index
							s_next.rsp_idx = sh[133:128];
							s_next.rsp1 = sh[127:96];
							s_next.rsp2 = sh[95:64];
							s_next.rsp3 = sh[63:32];
							s_next.rsp4 = {sh[31:1], 1'b0};
						end else begin
							s_next.rsp_idx = sh[45:40];
							s_next.rsp1 = sh[39:8];
						end
						// suspend reply tells data side to stop
						if (s_reg.cmd[SDH_CMD_SUSP_BIT]) begin
							wset[SDH_ST_SUSP] = 1'b1;
							s_next.susp = 1'b1;
						end
					end
				end
			end
			default: s_next.st = SDH_IDLE;
		endcase

		// Bus data phase writes
		if (s_reg.wr_pend) begin
			unique case (s_reg.wr_addr)
				SDH_OFF_ARG: s_next.arg = hwdata;
				SDH_OFF_CMD: begin
					s_next.cmd = wcmd;
					if (!wcmd[SDH_CMD_EN_BIT]) begin
						s_next.st = SDH_IDLE;
						s_next.line_oe = 1'b0;
						s_next.line_out = 1'b1;
					end else if (s_reg.st == SDH_IDLE) begin
						s_next.st = SDH_PEND;
					end
				end
				SDH_OFF_CLK: begin
					s_next.divisor = hwdata[SDH_DIV_WIDTH-1:0];
					s_next.bypass = hwdata[SDH_CLK_BYP_BIT];
				end
				SDH_OFF_STAT: wclr = hwdata[SDH_ST_WIDTH-1:0];
				default: ;
			endcase
		end
		// Write-one-to-clear; a same-cycle set wins
		s_next.flags = (s_reg.flags & ~wclr) | wset;
		s_next.flags[SDH_ST_BUSY] = 1'b0;
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			s_reg.arg <= SDH_ARG_RST;
			s_reg.rsp1 <= SDH_RSP_RST;
			s_reg.rsp2 <= SDH_RSP_RST;
			s_reg.rsp3 <= SDH_RSP_RST;
			s_reg.rsp4 <= SDH_RSP_RST;
			s_reg.line_out <= 1'b1;
			s_reg.ready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register, hresp tied low
	assign hreadyout = s_reg.ready;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign cmd_out = s_reg.line_out;
	assign cmd_oe = s_reg.line_oe;
	assign suspend_done = s_reg.susp;
endmodule : sdh_cmd_path
`default_nettype wire

//--- sdh_cmd_path_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic card_clock_pin,
	input wire logic cmd_out,
	input wire logic cmd_oe,
	input wire logic suspend_done
);
	logic [7:0] fcnt_reg;
	logic pin_d_reg;
	logic fell_d_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Card clock falls counted while the line is driven
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) fcnt_reg <= 8'h00;
		else if (!cmd_oe) fcnt_reg <= 8'h00;
		else if ($fell(card_clock_pin)) fcnt_reg <= fcnt_reg + 8'h01;
	end
	// Card clock fall seen one host clock late, as the line logic sees it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_d_reg <= 1'b0;
			fell_d_reg <= 1'b0;
		end else begin
			pin_d_reg <= card_clock_pin;
			fell_d_reg <= pin_d_reg & ~card_clock_pin;
		end
	end
	a_ready_high: assert property (hreadyout) else $error("bus stalled");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_start_low: assert property ($rose(cmd_oe) |-> !cmd_out) else $error("no start bit");
	a_oe_on_fall: assert property ($changed(cmd_oe) |-> fell_d_reg) else $error("enable off edge");
	a_bit_on_fall: assert property (cmd_oe && $changed(cmd_out) |-> fell_d_reg)
		else $error("bit off edge");
	a_frame_len: assert property ($fell(cmd_oe) |-> fcnt_reg == 8'h30) else $error("frame length");
	a_end_high: assert property ($fell(cmd_oe) |-> $past(cmd_out)) else $error("no end bit");
	a_susp_pulse: assert property (suspend_done |=> !suspend_done) else $error("long pulse");
	a_susp_quiet: assert property (suspend_done |-> !cmd_oe) else $error("pulse while sending");
endmodule : sdh_chk
bind sdh_cmd_path sdh_chk u_chk (.clk_sys, .reset_n, .hreadyout, .hresp, .card_clock_pin, .cmd_out, .cmd_oe,
	.suspend_done);
`default_nettype wire

//--- sdh_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_card_model (
	input wire logic card_clock_pin,
	input wire logic cmd_out,
	input wire logic cmd_oe,
	input wire logic card_irq,
	input wire logic [5:0] mode,
	input wire logic [5:0] ridx,
	input wire logic [127:0] rdat,
	input wire logic [3:0] dly,
	output logic cmd_in,
	output logic [47:0] got,
	output int n_got
);
	logic [135:0] fr;
	int n;
	initial begin
		cmd_in = 1'b1;
		n_got = 0;
	end
	// Capture one host frame, then answer as asked
	always begin
		@(posedge card_clock_pin iff (cmd_oe && !cmd_out));
		got = 48'h0;
		repeat (47) @(posedge card_clock_pin) got = {got[46:0], cmd_out};
		n_got++;
		// answer only on odd wait codes
		if (mode[0]) begin
			if (mode[2]) wait (card_irq);
			// both lengths, status sent MSB first
			fr = mode[1] ? {2'b00, 6'h3F, rdat[127:1], 1'b1} : {2'b00, ridx, rdat[31:0], 7'h00, 1'b1, 88'h0};
			n = mode[1] ? 136 : 48;
			repeat (dly + 2) @(negedge card_clock_pin);
			repeat (n) begin
				cmd_in = fr[135];
				fr = fr << 1;
				@(negedge card_clock_pin);
			end
			cmd_in = 1'b1; // Pull-up once released
		end
	end
endmodule : sdh_card_model
`default_nettype wire

//--- sd_host_command_path_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sd_host_command_path_tb_top import sdh_pkg::*; ;
	logic clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, data_busy = 1'b0, card_irq = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, q, arg, rs = 32'hCB10;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [5:0] mode = '0, ridx = '0, w, idx, eidx = '0;
	logic [5:0] tab [8] = '{6'h11, 6'h13, 6'h10, 6'h12, 6'h31, 6'h19, 6'h15, 6'h01};
	logic [127:0] rdat = '0;
	logic [3:0] dly = '0;
	logic [31:0] e [4] = '{default: 32'h0};
	wire logic hready, hreadyout, hresp, card_clock_pin, cmd_out, cmd_oe, cmd_in, suspend_done;
	wire logic [31:0] hrdata;
	wire logic [47:0] got;
	int n_got, n0, cyc = 0, n_mismatch = 0, checks_done = 0;
	assign hready = hreadyout;
	sdh_cmd_path u_dut (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .card_clock_pin, .cmd_out, .cmd_oe, .cmd_in, .data_busy, .card_irq, .suspend_done);
	sdh_card_model u_card (.card_clock_pin, .cmd_out, .cmd_oe, .card_irq, .mode, .ridx, .rdat, .dly, .cmd_in,
		.got, .n_got);
	// Clock and cycle count
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// One single AHB-Lite word transfer
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			n_mismatch++;
			$display("FAIL t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic per(input logic [31:0] v, input int x);
		int t;
		bus(SDH_OFF_CLK, 1'b1, v);
		repeat (2) @(posedge card_clock_pin);
		t = cyc;
		@(posedge card_clock_pin);
		chk(cyc - t, x);
	endtask : per
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	// Watchdog
	initial begin
		#250000;
		n_mismatch++;
		close_out();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 5; i++) begin
			bus(SDH_OFF_RSPIDX + 8'(4 * i), 1'b1, rnd());
			bus(SDH_OFF_RSPIDX + 8'(4 * i), 1'b0, 32'h0);
			chk(q, 32'h0);
		end
		bus(8'h40, 1'b1, rnd());
		bus(8'h40, 1'b0, 32'h0);
		chk(q, 32'h0);
		per(32'h0, 2);
		per(32'h3, 5);
		per(32'h100, 2);
		bus(SDH_OFF_CLK, 1'b1, 32'h2);
		for (int k = 0; k < 8; k++) begin
			w = tab[k];
			idx = 6'(rnd());
			arg = rnd();
			rdat <= {rnd(), rnd(), rnd(), rnd()};
			mode <= w;
			ridx <= idx;
			dly <= 4'(rnd());
			data_busy <= w[3];
			n0 = n_got;
			bus(SDH_OFF_ARG, 1'b1, arg);
			bus(SDH_OFF_CMD, 1'b1, {20'h0, w, idx});
			if (!w[4] || w[3]) begin
				repeat (100) @(posedge clk_sys);
				chk(n_got, n0);
				data_busy <= 1'b0;
			end
			if (!w[4]) continue;
			for (int t = 0; t < 2000 && n_got == n0; t++) @(posedge clk_sys);
			chk(got[39:8], arg);
			chk({got[47:40], got[0]}, {2'b01, idx, 1'b1});
			if (w[2]) begin
				repeat (300) @(posedge clk_sys);
				bus(SDH_OFF_STAT, 1'b0, 32'h0);
				chk(q[SDH_ST_TMO], 1'b0);
				card_irq <= 1'b1;
			end
			do bus(SDH_OFF_STAT, 1'b0, 32'h0); while (q[SDH_ST_BUSY] !== 1'b0 && cyc < 45000);
			card_irq <= 1'b0;
			chk(q[SDH_ST_RSP], w[0]);
			chk(q[SDH_ST_SUSP], w[5]);
			if (w[0]) begin
				eidx = w[1] ? 6'h3F : idx;
				if (w[1]) e = '{rdat[127:96], rdat[95:64], rdat[63:32], {rdat[31:1], 1'b0}};
				else e[0] = rdat[31:0];
			end
			bus(SDH_OFF_RSPIDX, 1'b0, 32'h0);
			chk(q, {26'h0, eidx});
			for (int i = 0; i < 4; i++) begin
				bus(SDH_OFF_RSP1 + 8'(4 * i), 1'b0, 32'h0);
				chk(q, e[i]);
			end
			bus(SDH_OFF_STAT, 1'b1, 32'h3E);
		end
		close_out();
	end
endmodule : sd_host_command_path_tb_top
`default_nettype wire
